// [src/sds_pkg.sv]
package sds_pkg;

  localparam logic [7:0] REG_DATA_IDX = 8'h31;
  localparam logic [7:0] REG_CTRL_IDX = 8'h32;
  localparam logic [7:0] REG_CSR_IDX = 8'h33;
  localparam logic [7:0] REG_ISTS_IDX = 8'h38;
  localparam logic [7:0] REG_IMASK_IDX = 8'h39;

  localparam int CTRL_IE_BIT = 7;
  localparam int CTRL_PE_BIT = 6;
  localparam int CTRL_SPR2_BIT = 5;
  localparam int CTRL_MODE_BIT = 4;
  localparam int CTRL_CPOL_BIT = 3;
  localparam int CTRL_CPHA_BIT = 2;
  localparam int CTRL_SPR1_BIT = 1;
  localparam int CTRL_SPR0_BIT = 0;

  localparam int CSR_RSVD_BIT = 3;
  localparam int CSR_OD_BIT = 2;
  localparam int CSR_SOFT_BIT = 1;
  localparam int CSR_LEVEL_BIT = 0;

  localparam int EV_DONE = 0;
  localparam int EV_MASTER_FAULT_FLAG = 1;
  localparam int EV_OVR = 2;
  localparam int EV_WRITE_COLLISION_FLAG = 3;
  localparam int NUM_EV = 4;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [2:0] CSR_CFG_RESET = 3'h0;
  localparam logic [3:0] IMASK_RESET = 4'hF;
  // Pin order is {select_n, miso, mosi, sck}; select idles high.
  localparam logic [3:0] PIN_RESET = 4'h8;

  // Half periods of the generated serial clock, in core clock cycles.
  localparam logic [6:0] HALF_DIV4 = 7'h02;
  localparam logic [6:0] HALF_DIV8 = 7'h04;
  localparam logic [6:0] HALF_DIV16 = 7'h08;
  localparam logic [6:0] HALF_DIV32 = 7'h10;
  localparam logic [6:0] HALF_DIV64 = 7'h20;
  localparam logic [6:0] HALF_DIV128 = 7'h40;
  localparam logic [3:0] LAST_EDGE = 4'hF;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic {
    ENG_IDLE = 1'b0,
    ENG_RUN = 1'b1
  } sds_eng_state_t;

endpackage

// [src/sds_link_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface sds_link_if;
  logic load;
  logic [7:0] tx_byte;
  logic enable;
  logic master;
  logic cpol;
  logic cpha;
  logic [2:0] rate;
  logic sel_n;
  logic sck_in;
  logic sdi;
  logic busy;
  logic done;
  logic [7:0] rx_byte;
  logic sck_out;
  logic sdo;
  modport ctl(output load, tx_byte, enable, master, cpol, cpha, rate, sel_n, sck_in, sdi,
              input busy, done, rx_byte, sck_out, sdo);
  modport eng(input load, tx_byte, enable, master, cpol, cpha, rate, sel_n, sck_in, sdi,
              output busy, done, rx_byte, sck_out, sdo);
endinterface
`default_nettype wire

// [src/sds_shifter.sv]
`timescale 1ns/1ps
`default_nettype none
module sds_shifter
  import sds_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  sds_link_if.eng lk
);

  sds_eng_state_t state_q;
  logic [7:0] shreg_q;
  logic out_q;
  logic [3:0] edge_q;
  logic [6:0] div_q;
  logic sck_q;
  logic sck_prev_q;
  logic done_q;
  logic [6:0] half;
  logic m_tick;
  logic s_edge;
  logic edge_ev;

  always_comb begin
    unique case (lk.rate)
      3'h4: half = HALF_DIV4;
      3'h0: half = HALF_DIV8;
      3'h1: half = HALF_DIV16;
      3'h6: half = HALF_DIV32;
      3'h2: half = HALF_DIV64;
      3'h3: half = HALF_DIV128;
      default: half = HALF_DIV8;
    endcase
  end

  assign m_tick = lk.master && (state_q == ENG_RUN) && (div_q == half - 7'h01);
  // Slave edges come from the filtered pin level, so they lag the pin by a few cycles.
  assign s_edge = !lk.master && !lk.sel_n && (lk.sck_in != sck_prev_q);
  assign edge_ev = m_tick || s_edge;

  always_ff @(posedge aclk) begin
    if (!aresetn || !lk.enable) begin
      state_q <= ENG_IDLE;
      shreg_q <= 8'h00;
      out_q <= 1'b0;
      edge_q <= 4'h0;
      div_q <= 7'h00;
      sck_q <= 1'b0;
      // Track the pin while idle so enabling with a high idle clock gives no false edge.
      sck_prev_q <= lk.sck_in;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      sck_prev_q <= lk.sck_in;
      div_q <= (edge_ev || state_q == ENG_IDLE) ? 7'h00 : div_q + 7'h01;
      if (lk.load && state_q == ENG_IDLE) begin
        shreg_q <= lk.tx_byte;
        out_q <= lk.tx_byte[7];
        edge_q <= 4'h0;
        sck_q <= lk.cpol;
        if (lk.master) begin
          state_q <= ENG_RUN;
        end
      end else if (!lk.master && lk.sel_n) begin
        state_q <= ENG_IDLE;
        edge_q <= 4'h0;
      end else if (edge_ev) begin
        sck_q <= lk.master ? !sck_q : lk.cpol;
        if (edge_q[0] == lk.cpha) begin
          shreg_q <= {shreg_q[6:0], lk.sdi};
        end else begin
          out_q <= shreg_q[7];
        end
        edge_q <= edge_q + 4'h1;
        state_q <= ENG_RUN;
        if (edge_q == LAST_EDGE) begin
          state_q <= ENG_IDLE;
          done_q <= 1'b1;
        end
      end else if (state_q == ENG_IDLE) begin
        sck_q <= lk.cpol;
      end
    end
  end

  assign lk.busy = (state_q == ENG_RUN);
  assign lk.done = done_q;
  assign lk.rx_byte = shreg_q;
  assign lk.sck_out = sck_q;
  assign lk.sdo = out_q;

endmodule
`default_nettype wire

// [src/sds_top.sv]
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module sds_top
  import sds_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe,
  input wire logic select_n_i,
  output logic irq
);

  localparam logic [ADDR_W-1:0] A_DATA = ADDR_W'({REG_DATA_IDX, 2'b00});
  localparam logic [ADDR_W-1:0] A_CTRL = ADDR_W'({REG_CTRL_IDX, 2'b00});
  localparam logic [ADDR_W-1:0] A_CSR = ADDR_W'({REG_CSR_IDX, 2'b00});
  localparam logic [ADDR_W-1:0] A_ISTS = ADDR_W'({REG_ISTS_IDX, 2'b00});
  localparam logic [ADDR_W-1:0] A_IMASK = ADDR_W'({REG_IMASK_IDX, 2'b00});

  sds_link_if lk();

  sds_shifter u_eng (
    .aclk(aclk),
    .aresetn(aresetn),
    .lk(lk)
  );

  logic aw_full_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic w_full_q;
  logic [7:0] w_data_q;
  logic w_lane_q;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [3:0] s1_q;
  logic [3:0] s2_q;
  logic [3:0] s3_q;
  logic [3:0] lvl_q;
  logic [7:0] ctrl_q;
  logic [2:0] csr_cfg_q;
  logic done_q;
  logic write_collision_flag_q;
  logic ovr_q;
  logic master_fault_flag_q;
  logic master_fault_flag_arm_q;
  logic seen_acc_q;
  logic seen_rd_q;
  logic [7:0] rxbuf_q;
  logic load_q;
  logic [7:0] tx_q;
  logic [NUM_EV-1:0] ists_q;
  logic [NUM_EV-1:0] imask_q;
  logic irq_q;
  logic sck_o_q;
  logic sck_oe_q;
  logic mosi_o_q;
  logic mosi_oe_q;
  logic miso_o_q;
  logic miso_oe_q;

  logic aw_take;
  logic w_take;
  logic wr_fire;
  logic wr_en;
  logic wr_data;
  logic wr_ctrl;
  logic wr_csr;
  logic wr_ists;
  logic wr_imask;
  logic wr_mapped;
  logic rd_take;
  logic rd_data;
  logic rd_csr;
  logic rd_mapped;
  logic [7:0] rd_val;
  logic csr_acc;
  logic data_acc;
  logic int_ss_n;
  logic fault;
  logic busy_any;
  logic data_ok;
  logic ovr_set;
  logic write_collision_flag_set;
  logic done_clr;
  logic [NUM_EV-1:0] ev;

  // Register bus decode.
  assign aw_take = s_axi_awvalid && awready_q;
  assign w_take = s_axi_wvalid && wready_q;
  assign wr_fire = aw_full_q && w_full_q && !bvalid_q;
  assign wr_en = wr_fire && w_lane_q;
  assign wr_data = wr_en && (aw_addr_q == A_DATA);
  assign wr_ctrl = wr_en && (aw_addr_q == A_CTRL);
  assign wr_csr = wr_en && (aw_addr_q == A_CSR);
  assign wr_ists = wr_en && (aw_addr_q == A_ISTS);
  assign wr_imask = wr_en && (aw_addr_q == A_IMASK);
  assign wr_mapped = (aw_addr_q == A_DATA) || (aw_addr_q == A_CTRL) || (aw_addr_q == A_CSR) ||
                     (aw_addr_q == A_ISTS) || (aw_addr_q == A_IMASK);
  assign rd_take = s_axi_arvalid && arready_q;
  assign rd_data = rd_take && (s_axi_araddr == A_DATA);
  assign rd_csr = rd_take && (s_axi_araddr == A_CSR);
  assign csr_acc = rd_csr || wr_csr;
  assign data_acc = rd_data || wr_data;

  always_comb begin
    rd_mapped = 1'b1;
    rd_val = 8'h00;
    unique case (s_axi_araddr)
      A_DATA: rd_val = rxbuf_q;
      A_CTRL: rd_val = ctrl_q;
      A_CSR: rd_val = {done_q, write_collision_flag_q, ovr_q, master_fault_flag_q, 1'b0, csr_cfg_q};
      A_ISTS: rd_val = {4'h0, ists_q};
      A_IMASK: rd_val = {4'h0, imask_q};
      default: rd_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= '0;
      w_full_q <= 1'b0;
      w_data_q <= 8'h00;
      w_lane_q <= 1'b0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_full_q <= 1'b0;
      end
      if (w_take) begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata[7:0];
        w_lane_q <= s_axi_wstrb[0];
      end else if (wr_fire) begin
        w_full_q <= 1'b0;
      end
      awready_q <= wr_fire || !(aw_full_q || aw_take);
      wready_q <= wr_fire || !(w_full_q || w_take);
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else if (rd_take) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= {24'h00_0000, rd_val};
      rresp_q <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
    end
  end

  // Pins cross in with three flops; a level counts once the last two agree.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= PIN_RESET;
      s2_q <= PIN_RESET;
      s3_q <= PIN_RESET;
      lvl_q <= PIN_RESET;
    end else begin
      s1_q <= {select_n_i, miso_i, mosi_i, sck_i};
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & lvl_q);
    end
  end

  assign int_ss_n = csr_cfg_q[CSR_SOFT_BIT] ? csr_cfg_q[CSR_LEVEL_BIT] : lvl_q[3];
  assign fault = ctrl_q[CTRL_MODE_BIT] && !int_ss_n;
  assign busy_any = lk.busy || load_q;
  // A write while the done flag is unread is dropped rather than queued.
  assign data_ok = wr_data && !busy_any && !(done_q && !seen_rd_q);
  assign ovr_set = lk.done && done_q;
  assign write_collision_flag_set = wr_data && busy_any;
  assign done_clr = seen_acc_q && data_acc;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= CTRL_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= w_data_q;
      end
      if (fault) begin
        ctrl_q[CTRL_PE_BIT] <= 1'b0;
        ctrl_q[CTRL_MODE_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      csr_cfg_q <= CSR_CFG_RESET;
    end else if (wr_csr) begin
      csr_cfg_q <= w_data_q[2:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_q <= 1'b0;
      write_collision_flag_q <= 1'b0;
      seen_acc_q <= 1'b0;
      seen_rd_q <= 1'b0;
    end else begin
      if (lk.done) begin
        done_q <= 1'b1;
      end else if (done_clr) begin
        done_q <= 1'b0;
      end
      if (write_collision_flag_set) begin
        write_collision_flag_q <= 1'b1;
      end else if (done_clr) begin
        write_collision_flag_q <= 1'b0;
      end
      seen_acc_q <= !done_clr && (seen_acc_q || (csr_acc && (done_q || write_collision_flag_q)));
      seen_rd_q <= !done_clr && done_q && (seen_rd_q || rd_csr);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ovr_q <= 1'b0;
    end else if (ovr_set) begin
      ovr_q <= 1'b1;
    end else if (rd_csr) begin
      ovr_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      master_fault_flag_q <= 1'b0;
      master_fault_flag_arm_q <= 1'b0;
    end else if (fault) begin
      master_fault_flag_q <= 1'b1;
      master_fault_flag_arm_q <= master_fault_flag_arm_q || (csr_acc && master_fault_flag_q);
    end else if (master_fault_flag_arm_q && wr_ctrl) begin
      master_fault_flag_q <= 1'b0;
      master_fault_flag_arm_q <= 1'b0;
    end else begin
      master_fault_flag_arm_q <= master_fault_flag_arm_q || (csr_acc && master_fault_flag_q);
    end
  end

  // On overrun the buffer keeps the older byte; the new one is lost.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rxbuf_q <= 8'h00;
    end else if (lk.done && !done_q) begin
      rxbuf_q <= lk.rx_byte;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      load_q <= 1'b0;
      tx_q <= 8'h00;
    end else begin
      load_q <= data_ok;
      if (data_ok) begin
        tx_q <= w_data_q;
      end
    end
  end

  assign ev = {write_collision_flag_set, ovr_set, fault && !master_fault_flag_q, lk.done};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ists_q <= '0;
      imask_q <= IMASK_RESET;
      irq_q <= 1'b0;
    end else begin
      ists_q <= (ists_q & ~(wr_ists ? w_data_q[NUM_EV-1:0] : '0)) | ev;
      if (wr_imask) begin
        imask_q <= w_data_q[NUM_EV-1:0];
      end
      irq_q <= ctrl_q[CTRL_IE_BIT] && |(ists_q & imask_q);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sck_o_q <= 1'b0;
      sck_oe_q <= 1'b0;
      mosi_o_q <= 1'b0;
      mosi_oe_q <= 1'b0;
      miso_o_q <= 1'b0;
      miso_oe_q <= 1'b0;
    end else begin
      sck_o_q <= lk.sck_out;
      sck_oe_q <= ctrl_q[CTRL_PE_BIT] && ctrl_q[CTRL_MODE_BIT];
      mosi_o_q <= lk.sdo;
      mosi_oe_q <= ctrl_q[CTRL_PE_BIT] && ctrl_q[CTRL_MODE_BIT] && !csr_cfg_q[CSR_OD_BIT];
      miso_o_q <= lk.sdo;
      miso_oe_q <= ctrl_q[CTRL_PE_BIT] && !ctrl_q[CTRL_MODE_BIT] && !csr_cfg_q[CSR_OD_BIT] && !int_ss_n;
    end
  end

  assign lk.load = load_q;
  assign lk.tx_byte = tx_q;
  assign lk.enable = ctrl_q[CTRL_PE_BIT];
  assign lk.master = ctrl_q[CTRL_MODE_BIT];
  assign lk.cpol = ctrl_q[CTRL_CPOL_BIT];
  assign lk.cpha = ctrl_q[CTRL_CPHA_BIT];
  assign lk.rate = {ctrl_q[CTRL_SPR2_BIT], ctrl_q[CTRL_SPR1_BIT], ctrl_q[CTRL_SPR0_BIT]};
  assign lk.sel_n = int_ss_n;
  assign lk.sck_in = lvl_q[0];
  assign lk.sdi = ctrl_q[CTRL_MODE_BIT] ? lvl_q[2] : lvl_q[1];

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign sck_o = sck_o_q;
  assign sck_oe = sck_oe_q;
  assign mosi_o = mosi_o_q;
  assign mosi_oe = mosi_oe_q;
  assign miso_o = miso_o_q;
  assign miso_oe = miso_oe_q;
  assign irq = irq_q;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  ovr_set_a: assert property (lk.done && done_q |=> ovr_q)
    else $error("Overrun not flagged.");
  ovr_clear_a: assert property (rd_csr && !ovr_set |=> !ovr_q)
    else $error("Overrun not cleared by status read.");
  fault_flag_a: assert property (fault |=> master_fault_flag_q)
    else $error("Master fault not flagged.");
  fault_clear_a: assert property (master_fault_flag_arm_q && wr_ctrl && !fault |=> !master_fault_flag_q)
    else $error("Master fault not cleared.");
  rsvd_zero_a: assert property (rd_csr |=> rvalid_q && rdata_q[CSR_RSVD_BIT] == 1'b0)
    else $error("Reserved status bit read as one.");
  out_off_a: assert property (csr_cfg_q[CSR_OD_BIT] |=> !mosi_oe_q && !miso_oe_q)
    else $error("Data output driven while disabled.");
  pin_ignored_a: assert property (ctrl_q[CTRL_MODE_BIT] && csr_cfg_q[CSR_SOFT_BIT] &&
                                  csr_cfg_q[CSR_LEVEL_BIT] && !master_fault_flag_q |=> !master_fault_flag_q)
    else $error("Select pin not ignored in soft mode.");
  soft_select_a: assert property (ctrl_q[CTRL_MODE_BIT] && csr_cfg_q[CSR_SOFT_BIT] &&
                                  !csr_cfg_q[CSR_LEVEL_BIT] |=> master_fault_flag_q)
    else $error("Soft select level not used.");
  start_xfer_a: assert property (data_ok && ctrl_q[CTRL_MODE_BIT] && !fault |=> ##1 lk.busy)
    else $error("Data write did not start a transfer.");
  rx_buffer_a: assert property (lk.done && !done_q |=> rxbuf_q == $past(lk.rx_byte))
    else $error("Receive buffer not loaded.");
  write_inhibit_a: assert property (wr_data && done_q && !seen_rd_q |=> !load_q)
    else $error("Data write not inhibited.");
  direct_load_a: assert property (data_ok |=> load_q && tx_q == $past(w_data_q))
    else $error("Shift register not loaded directly.");
  done_set_a: assert property (lk.done |=> done_q)
    else $error("Transfer-done flag not set.");
  collision_a: assert property (write_collision_flag_set |=> write_collision_flag_q && !load_q)
    else $error("Write collision not flagged.");
  irq_raise_a: assert property (ctrl_q[CTRL_IE_BIT] && |(ists_q & imask_q) |=> irq_q)
    else $error("Interrupt not raised.");
  mode_drop_a: assert property (fault |=> !ctrl_q[CTRL_PE_BIT] && !ctrl_q[CTRL_MODE_BIT])
    else $error("Fault did not release the port.");

  xfer_done_c: cover property (lk.done);
  overrun_c: cover property (ovr_set);
  fault_clear_c: cover property (master_fault_flag_arm_q && wr_ctrl && !fault);
  collision_c: cover property (write_collision_flag_set);

endmodule
`default_nettype wire

// [sim/sds_peer.sv]
`timescale 1ns/1ps
`default_nettype none
module sds_peer #(
  parameter logic [7:0] REPLY = 8'h3C
) (
  input wire logic sck,
  input wire logic sel,
  input wire logic mosi,
  output logic miso,
  output logic [7:0] got,
  output int count
);
  logic [7:0] sh = REPLY;
  int nb = 0;
  initial begin
    got = 8'h00;
    count = 0;
  end
  // Samples on the leading rising edge and shifts on the trailing one, MSB first.
  always @(posedge sck) begin
    if (sel) begin
      got <= {got[6:0], mosi};
    end
  end
  always @(negedge sck) begin
    if (sel) begin
      if (nb == 7) begin
        nb <= 0;
        count <= count + 1;
        sh <= REPLY;
      end else begin
        nb <= nb + 1;
        sh <= {sh[6:0], 1'b0};
      end
    end
  end
  // A released line shows the inverse of its last level, so stale data cannot pass.
  assign miso = sel ? sh[7] : ~sh[7];
endmodule
`default_nettype wire

// [sim/tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  import sds_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h00000000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, sel_n = 1'b1;
  logic awready, wready, bvalid, arready, rvalid, irq, peer_miso;
  logic sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
  logic [31:0] rdata;
  logic [1:0] bresp, rresp, rd_r, wr_r;
  logic [7:0] got, rd_v;
  int count, n;
  int num_errors = 0;
  int compares = 0;
  wire sck_w = sck_oe ? sck_o : 1'b0;
  wire mosi_w = mosi_oe ? mosi_o : 1'b0;
  wire miso_w = miso_oe ? miso_o : peer_miso;

  sds_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sck_i(sck_w), .sck_o(sck_o),
    .sck_oe(sck_oe), .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_i(miso_w),
    .miso_o(miso_o), .miso_oe(miso_oe), .select_n_i(sel_n), .irq(irq));

  sds_peer i_peer (.sck(sck_w), .sel(sck_oe), .mosi(mosi_w), .miso(peer_miso), .got(got), .count(count));

  initial begin
    forever #4 aclk = ~aclk;
  end

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && k < 1000);
    wr_r = bresp;
    bready <= 1'b0;
    if (k >= 1000) num_errors++;
  endtask

  task automatic rd(input logic [11:0] a);
    int k;
    k = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid && k < 1000);
    rd_v = rdata[7:0];
    rd_r = rresp;
    rready <= 1'b0;
    if (k >= 1000) num_errors++;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    rd(a);
    `CHK(rd_v, e)
  endtask

  task automatic irq_chk(input logic e);
    repeat (3) @(posedge aclk);
    `CHK(irq, e)
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d, errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    #200000;
    num_errors++;
    print_verdict();
  end

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rchk(12'h0CC, 8'h00);
    rchk(12'h0C8, 8'h00);
    rchk(12'h0E4, 8'h0F);
    rd(12'h100);
    `CHK(rd_r, RESP_SLVERR)
    wr(12'h100, 8'h00);
    `CHK(wr_r, RESP_SLVERR)
    wr(12'h0CC, 8'h03);
    // Returned data crosses the pin synchroniser, so the bench runs the link at the divide-by-16 rate.
    wr(12'h0C8, 8'hD1);
    `CHK(wr_r, RESP_OKAY)
    sel_n <= 1'b0;
    repeat (8) @(posedge aclk);
    `CHK(mosi_oe, 1'b1)
    `CHK(miso_oe, 1'b0)
    wr(12'h0CC, 8'h07);
    repeat (3) @(posedge aclk);
    `CHK(mosi_oe, 1'b0)
    sel_n <= 1'b1;
    wr(12'h0CC, 8'h03);
    wr(12'h0C4, 8'hA5);
    wr(12'h0C4, 8'hFF);
    n = 0;
    while (count != 1 && n < 2000) begin
      @(posedge aclk);
      n++;
    end
    repeat (4) @(posedge aclk);
    `CHK(irq, 1'b1)
    // Writing here without a status read must not start a second byte.
    wr(12'h0C4, 8'h11);
    repeat (200) @(posedge aclk);
    `CHK(count, 1)
    `CHK(got, 8'hA5)
    rchk(12'h0CC, 8'hC3);
    rchk(12'h0C4, 8'h3C);
    rchk(12'h0CC, 8'h03);
    rchk(12'h0E0, 8'h09);
    wr(12'h0E0, 8'h09);
    irq_chk(1'b0);
    wr(12'h0CC, 8'h02);
    irq_chk(1'b1);
    `CHK(sck_oe, 1'b0)
    rchk(12'h0C8, 8'h81);
    rchk(12'h0CC, 8'h12);
    wr(12'h0CC, 8'h03);
    rchk(12'h0CC, 8'h13);
    wr(12'h0C8, 8'h80);
    rchk(12'h0CC, 8'h03);
    wr(12'h0E4, 8'h00);
    irq_chk(1'b0);
    wr(12'h0E4, 8'h0F);
    irq_chk(1'b1);
    wr(12'h0E0, 8'h02);
    irq_chk(1'b0);
    print_verdict();
  end
endmodule
`default_nettype wire
